/* File: rtl/tsevg_pkg.sv */
// Notes on behaviour
// - brake write clears output enable, sets flag
// - brake bit held until software clears it
// - trigger write sets trigger flag, requests
// - other generate bits self clear after acting
// - control update copies preload when enabled
// - output channel write sets compare flag
// - input channel write captures core counter
// - capture with flag set sets overcapture
// - bits two to four drive channels two-four
// - update write reinitialises counter, update event
// - update zeroes prescaler count, keeps factor
// - up or centre mode loads zero
// - down mode loads auto-reload value
// - update flag needs both source bits zero
package tsevg_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DMAEN = 8'h08;
  localparam logic [7:0] OFS_INTEN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVGEN = 8'h14;
  localparam logic [7:0] OFS_PRELOAD = 8'h20;
  localparam logic [7:0] OFS_ACTIVE = 8'h24;
  localparam logic [7:0] OFS_RELOAD = 8'h2C;
  localparam logic [7:0] OFS_CAP1 = 8'h34;
  // generate and status bit positions
  localparam int BIT_UPD = 0;
  localparam int BIT_CH1 = 1;
  localparam int BIT_COM = 5;
  localparam int BIT_TRG = 6;
  localparam int BIT_BRK = 7;
  localparam int BIT_OVC1 = 9;
  // control bit positions
  localparam int CTL_UPDATE_DISABLE = 0;
  localparam int CTL_URS = 1;
  localparam int CTL_CONTROL_PRELOAD_CONTROL = 2;
  localparam int CTL_MOE = 3;
  localparam int CTL_MODE = 4;
  localparam int CTL_CHIN = 6;
  localparam int CH_CTL_W = 5;
  localparam logic [1:0] MODE_DOWN = 2'h1;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [12:0] STATUS_MASK = 13'h1EFF;
  localparam logic [7:0] EVGEN_MASK = 8'hFF;
endpackage : tsevg_pkg

/* File: rtl/tsevg_top.sv */
`timescale 1ns/1ps
module tsevg_top
  import tsevg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] coreCount,
  output logic mainOutputEnable,
  output logic counterLoad,
  output logic [15:0] counterLoadValue,
  output logic prescalerClear,
  output logic triggerEvent,
  output logic [3:0] channelEvent,
  output logic [19:0] activeControl,
  output logic [12:0] dmaRequest,
  output logic irq
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] ctrl;
    logic [12:0] dmaEn;
    logic [12:0] intEn;
    logic [12:0] status;
    logic [7:0] evgen;
    logic [19:0] preload;
    logic [19:0] active;
    logic [15:0] reload;
    logic [3:0][15:0] capture;
    logic counterLoad;
    logic [15:0] counterLoadValue;
    logic prescalerClear;
    logic triggerEvent;
    logic [3:0] channelEvent;
    logic [12:0] dmaRequest;
    logic irq;
  } tsevg_state_s;

  tsevg_state_s cur;
  tsevg_state_s next_cur;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // sticky flag update, set wins over clear
  function automatic logic [12:0] stickyNext(input logic [12:0] old,
                                             input logic [12:0] clr,
                                             input logic [12:0] set);
    stickyNext = (old & ~clr) | set;
  endfunction : stickyNext

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic access;
  logic wrEn;
  logic [7:0] genWrite;
  logic [12:0] setBits;
  logic [12:0] clrBits;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_cur = cur;
    access = psel & penable & cur.pready;
    wrEn = access & pwrite;
    genWrite = 8'h00;
    setBits = 13'h0000;
    clrBits = 13'h0000;
    mapped = hit(paddr, OFS_CTRL) | hit(paddr, OFS_DMAEN) | hit(paddr, OFS_INTEN)
      | hit(paddr, OFS_STATUS) | hit(paddr, OFS_EVGEN) | hit(paddr, OFS_PRELOAD)
      | hit(paddr, OFS_ACTIVE) | hit(paddr, OFS_RELOAD)
      | (paddr[7:4] == OFS_CAP1[7:4] && paddr[1:0] == 2'h0 && paddr[3:2] != 2'h0)
      | hit(paddr, 8'h40);
    next_cur.counterLoad = 1'b0;
    next_cur.prescalerClear = 1'b0;
    next_cur.triggerEvent = 1'b0;
    next_cur.channelEvent = 4'h0;
    // generate bits other than the brake bit drop one cycle after acting
    next_cur.evgen = cur.evgen & 8'h80;
    // bus answer prepared in the setup cycle
    next_cur.pready = psel & ~penable;
    next_cur.pslverr = psel & ~penable & ~mapped;
    next_cur.prdata = 32'h00000000;
    if (psel & ~penable & ~pwrite)
    begin
      unique case (paddr)
        OFS_CTRL: next_cur.prdata = {22'h000000, cur.ctrl};
        OFS_DMAEN: next_cur.prdata = {19'h00000, cur.dmaEn};
        OFS_INTEN: next_cur.prdata = {19'h00000, cur.intEn};
        OFS_STATUS: next_cur.prdata = {19'h00000, cur.status};
        OFS_EVGEN: next_cur.prdata = 32'h00000000;
        OFS_PRELOAD: next_cur.prdata = {12'h000, cur.preload};
        OFS_ACTIVE: next_cur.prdata = {12'h000, cur.active};
        OFS_RELOAD: next_cur.prdata = {16'h0000, cur.reload};
        8'h34: next_cur.prdata = {16'h0000, cur.capture[0]};
        8'h38: next_cur.prdata = {16'h0000, cur.capture[1]};
        8'h3C: next_cur.prdata = {16'h0000, cur.capture[2]};
        8'h40: next_cur.prdata = {16'h0000, cur.capture[3]};
        default: next_cur.prdata = 32'h00000000;
      endcase
    end
    // plain register writes
    if (wrEn)
    begin
      unique case (paddr)
        OFS_CTRL: next_cur.ctrl = pwdata[9:0];
        OFS_DMAEN: next_cur.dmaEn = pwdata[12:0] & STATUS_MASK;
        OFS_INTEN: next_cur.intEn = pwdata[12:0] & STATUS_MASK;
        OFS_STATUS: clrBits = pwdata[12:0] & STATUS_MASK;
        OFS_EVGEN: genWrite = pwdata[7:0] & EVGEN_MASK;
        OFS_PRELOAD: next_cur.preload = pwdata[19:0];
        OFS_RELOAD: next_cur.reload = pwdata[15:0];
        default: next_cur.reload = cur.reload;
      endcase
    end
    // without preload control the active copy follows at once
    if (!cur.ctrl[CTL_CONTROL_PRELOAD_CONTROL])
      next_cur.active = next_cur.preload;
    else
      next_cur.active[19:15] = next_cur.preload[19:15];
    if (wrEn && hit(paddr, OFS_EVGEN))
    begin
      // brake bit kept until software writes zero
      next_cur.evgen = genWrite;
    end
    if (genWrite[BIT_BRK])
    begin
      next_cur.ctrl[CTL_MOE] = 1'b0;
      setBits[BIT_BRK] = 1'b1;
    end
    if (genWrite[BIT_TRG])
    begin
      setBits[BIT_TRG] = 1'b1;
      next_cur.triggerEvent = 1'b1;
    end
    if (genWrite[BIT_COM] && cur.ctrl[CTL_CONTROL_PRELOAD_CONTROL])
    begin
      next_cur.active[14:0] = next_cur.preload[14:0];
      setBits[BIT_COM] = 1'b1;
    end
    // one loop serves all four channels
    for (int ch = 0; ch < 4; ch++)
    begin
      if (genWrite[BIT_CH1 + ch])
      begin
        next_cur.channelEvent[ch] = 1'b1;
        setBits[BIT_CH1 + ch] = 1'b1;
        if (cur.ctrl[CTL_CHIN + ch])
        begin
          next_cur.capture[ch] = coreCount;
          if (cur.status[BIT_CH1 + ch])
            setBits[BIT_OVC1 + ch] = 1'b1;
        end
      end
    end
    if (genWrite[BIT_UPD])
    begin
      next_cur.counterLoad = 1'b1;
      next_cur.prescalerClear = 1'b1;
      if (cur.ctrl[CTL_MODE +: 2] == MODE_DOWN)
        next_cur.counterLoadValue = cur.reload;
      // up and centre modes start at zero
      else
        next_cur.counterLoadValue = 16'h0000;
      // flag only with both source bits zero
      if (!cur.ctrl[CTL_URS] && !cur.ctrl[CTL_UPDATE_DISABLE])
        setBits[BIT_UPD] = 1'b1;
    end
    next_cur.status = stickyNext(cur.status, clrBits, setBits) & STATUS_MASK;
    next_cur.irq = |(next_cur.status & cur.intEn);
    next_cur.dmaRequest = next_cur.status & cur.dmaEn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.ctrl <= CTRL_RESET;
    end
    else
      cur <= next_cur;
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign mainOutputEnable = cur.ctrl[CTL_MOE];
  assign counterLoad = cur.counterLoad;
  assign counterLoadValue = cur.counterLoadValue;
  assign prescalerClear = cur.prescalerClear;
  assign triggerEvent = cur.triggerEvent;
  assign channelEvent = cur.channelEvent;
  assign activeControl = cur.active;
  assign dmaRequest = cur.dmaRequest;
  assign irq = cur.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic evWr;
  assign evWr = psel & penable & pready & pwrite & (paddr == OFS_EVGEN);

  a_brake_clears_moe: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[7] |=> !mainOutputEnable && cur.status[7])
    else $error("brake write did not clear enable");

  a_brake_bit_holds: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[7] |=> cur.evgen[7] [*1] ##1 (cur.evgen[7] || $past(evWr)))
    else $error("brake bit lost");

  a_trigger_sets_flag: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[6] |=> triggerEvent && cur.status[6] ##1 !triggerEvent)
    else $error("trigger event missing");

  a_gen_bits_clear: assert property (@(posedge clk) disable iff (rst)
    evWr |=> ##1 (cur.evgen[6:0] == 7'h00 || $past(evWr)))
    else $error("generate bits not cleared");

  a_com_copies_preload: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[5] && cur.ctrl[2] |=> activeControl[14:0] == cur.preload[14:0])
    else $error("control update not applied");

  a_com_skips_ch4: assert property (@(posedge clk) disable iff (rst)
    cur.ctrl[2] && !(psel && pwrite && paddr == OFS_PRELOAD) |=> $stable(activeControl[19:15]))
    else $error("fourth channel changed");

  a_chan_flag_set: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[1] |=> cur.status[1] && channelEvent[0])
    else $error("channel flag not set");

  a_capture_count: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[2] && cur.ctrl[7] |=> cur.capture[1] == $past(coreCount))
    else $error("capture value wrong");

  a_overcapture_set: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[1] && cur.ctrl[6] && cur.status[1] |=> cur.status[9])
    else $error("overcapture not flagged");

  a_update_load: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[0] |=> counterLoad && prescalerClear ##1 !counterLoad)
    else $error("update pulse wrong");

  a_down_reload: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[0] && cur.ctrl[5:4] == 2'h1 |=> counterLoadValue == $past(cur.reload))
    else $error("down mode load wrong");

  a_up_zero: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[0] && cur.ctrl[5:4] != 2'h1 |=> counterLoadValue == 16'h0000)
    else $error("up mode load wrong");

  a_update_flag_gate: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[0] && (cur.ctrl[0] || cur.ctrl[1]) && !cur.status[0]
      && !(psel && pwrite && paddr == OFS_STATUS) |=> !cur.status[0])
    else $error("update flag set while blocked");

  a_evgen_reads_zero: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && paddr == OFS_EVGEN |=> prdata == 32'h00000000)
    else $error("event register read nonzero");

  a_ch2_event: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[2] |=> cur.status[2] && channelEvent[1])
    else $error("channel two event missing");

  a_ch3_capture: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[3] && cur.ctrl[8] |=> cur.capture[2] == $past(coreCount))
    else $error("channel three capture wrong");

  a_ch4_event: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[4] |=> cur.status[4] && channelEvent[3])
    else $error("channel four event missing");

  a_output_keeps_cap: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[1] && !cur.ctrl[6] |=> $stable(cur.capture[0]))
    else $error("output channel captured");

  a_com_needs_control_preload_control: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[5] && !cur.ctrl[2] && !cur.status[5] |=> !cur.status[5])
    else $error("control update flag without preload");

  a_trigger_only_write: assert property (@(posedge clk) disable iff (rst)
    !(evWr && pwdata[6]) |=> !triggerEvent)
    else $error("spurious trigger event");

  a_load_only_update: assert property (@(posedge clk) disable iff (rst)
    !(evWr && pwdata[0]) |=> !counterLoad)
    else $error("spurious counter load");

  a_psc_with_load: assert property (@(posedge clk) disable iff (rst)
    prescalerClear == counterLoad)
    else $error("prescaler clear without load");

  a_zero_write_idle: assert property (@(posedge clk) disable iff (rst)
    evWr && pwdata[7:0] == 8'h00 |=> !counterLoad && !triggerEvent && channelEvent == 4'h0)
    else $error("zero write caused an event");

  a_pready_after_setup: assert property (@(posedge clk) disable iff (rst)
    psel && !penable |=> pready)
    else $error("no answer after setup");

  a_pready_one_cycle: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready held too long");

  a_unmapped_err: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && paddr == 8'h04 |=> pslverr && pready)
    else $error("unmapped address accepted");

  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    $stable(cur.intEn) |-> irq == (|(cur.status & cur.intEn)))
    else $error("interrupt level wrong");

  a_dma_level: assert property (@(posedge clk) disable iff (rst)
    $stable(cur.dmaEn) |-> dmaRequest == (cur.status & cur.dmaEn))
    else $error("dma request level wrong");

  c_brake: cover property (@(posedge clk) disable iff (rst) evWr && pwdata[7]);
  c_capture: cover property (@(posedge clk) disable iff (rst) cur.status[9]);
  c_update: cover property (@(posedge clk) disable iff (rst) counterLoad);
  c_irq: cover property (@(posedge clk) disable iff (rst) irq);
  c_com: cover property (@(posedge clk) disable iff (rst) evWr && pwdata[5] && cur.ctrl[2]);

endmodule : tsevg_top

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import tsevg_pkg::*;
  typedef struct packed {logic [9:0] ctrl; logic [7:0] ev; logic [12:0] st; logic [9:0] ctl2;}
    tsevg_row_s;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, errSeen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] coreCount, counterLoadValue;
  logic mainOutputEnable, counterLoad, prescalerClear, triggerEvent;
  logic [3:0] channelEvent;
  logic [19:0] activeControl;
  logic [12:0] dmaRequest;
  int n_errors = 0;
  int samples_checked = 0;
  tsevg_row_s rows [9] = '{'{10'h000, 8'h01, 13'h0001, 10'h000},
    '{10'h002, 8'h01, 13'h0000, 10'h002}, '{10'h001, 8'h01, 13'h0000, 10'h001},
    '{10'h000, 8'h40, 13'h0040, 10'h000}, '{10'h000, 8'h1E, 13'h001E, 10'h000},
    '{10'h004, 8'h20, 13'h0020, 10'h004}, '{10'h000, 8'h20, 13'h0000, 10'h000},
    '{10'h008, 8'h80, 13'h0080, 10'h000}, '{10'h008, 8'h00, 13'h0000, 10'h008}};
  `define CHK(nm, exp, got) \
    begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
        n_errors++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
      end \
    end
  //////////////////////////////////////////////////////////////////////////////
  tsevg_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .coreCount(coreCount), .mainOutputEnable(mainOutputEnable), .counterLoad(counterLoad),
    .counterLoadValue(counterLoadValue), .prescalerClear(prescalerClear),
    .triggerEvent(triggerEvent), .channelEvent(channelEvent), .activeControl(activeControl),
    .dmaRequest(dmaRequest), .irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      n_errors++;
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wrt
  task automatic chkReg(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, exp, rd)
  endtask : chkReg
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    n_errors++;
    end_sim();
  end
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    coreCount = 16'h0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("moe", 1'b0, mainOutputEnable)
    chkReg("ctrl", OFS_CTRL, 32'h0000_0000);
    chkReg("evgen", OFS_EVGEN, 32'h0000_0000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK("slverr", 1'b1, errSeen)
    apb(1'b0, 8'h30, 32'h0000_0000);
    `CHK("slverr30", 1'b1, errSeen)
    apb(1'b0, 8'h3C, 32'h0000_0000);
    `CHK("slverr3c", 1'b0, errSeen)
    $display("reset test done");
    foreach (rows[i])
    begin
      wrt(OFS_STATUS, 32'h0000_1FFF);
      wrt(OFS_CTRL, {22'h0, rows[i].ctrl});
      wrt(OFS_EVGEN, {24'h0, rows[i].ev});
      chkReg("status", OFS_STATUS, {19'h0, rows[i].st});
      chkReg("ctrl", OFS_CTRL, {22'h0, rows[i].ctl2});
      chkReg("evgen", OFS_EVGEN, 32'h0000_0000);
    end
    $display("table test done");
    wrt(OFS_STATUS, 32'h0000_1FFF);
    wrt(OFS_CTRL, 32'h0000_0004);
    wrt(OFS_PRELOAD, 32'h000F_FFFF);
    chkReg("active", OFS_ACTIVE, 32'h000F_8000);
    wrt(OFS_EVGEN, 32'h0000_0020);
    chkReg("active", OFS_ACTIVE, 32'h000F_FFFF);
    `CHK("activeport", 20'hFFFFF, activeControl)
    $display("control update test done");
    wrt(OFS_STATUS, 32'h0000_1FFF);
    wrt(OFS_CTRL, 32'h0000_0040);
    coreCount <= 16'h1234;
    wrt(OFS_EVGEN, 32'h0000_0002);
    @(posedge clk);
    `CHK("chevent", 4'h1, channelEvent)
    chkReg("cap1", OFS_CAP1, 32'h0000_1234);
    chkReg("status", OFS_STATUS, 32'h0000_0002);
    coreCount <= 16'h5678;
    wrt(OFS_EVGEN, 32'h0000_0002);
    chkReg("cap1", OFS_CAP1, 32'h0000_5678);
    chkReg("status", OFS_STATUS, 32'h0000_0202);
    wrt(OFS_INTEN, 32'h0000_0200);
    chkReg("inten", OFS_INTEN, 32'h0000_0200);
    `CHK("irq", 1'b1, irq)
    wrt(OFS_INTEN, 32'h0000_0000);
    wrt(OFS_DMAEN, 32'h0000_0002);
    chkReg("inten", OFS_INTEN, 32'h0000_0000);
    `CHK("irqmask", 1'b0, irq)
    `CHK("dma", 13'h0002, dmaRequest)
    wrt(OFS_INTEN, 32'h0000_0200);
    wrt(OFS_STATUS, 32'h0000_0200);
    chkReg("status", OFS_STATUS, 32'h0000_0002);
    `CHK("irqclr", 1'b0, irq)
    $display("capture test done");
    wrt(OFS_RELOAD, 32'h0000_ABCD);
    for (int m = 0; m < 4; m++)
    begin
      wrt(OFS_CTRL, 32'(m) << CTL_MODE);
      wrt(OFS_EVGEN, 32'h0000_0001);
      @(posedge clk);
      `CHK("load", 1'b1, counterLoad)
      `CHK("psclr", 1'b1, prescalerClear)
      `CHK("loadval", (2'(m) === MODE_DOWN) ? 16'hABCD : 16'h0000, counterLoadValue)
      @(posedge clk);
      `CHK("loadoff", 1'b0, counterLoad)
    end
    $display("update test done");
    wrt(OFS_CTRL, 32'h0000_0008);
    wrt(OFS_EVGEN, 32'h0000_0040);
    @(posedge clk);
    `CHK("trigger", 1'b1, triggerEvent)
    `CHK("moeon", 1'b1, mainOutputEnable)
    wrt(OFS_EVGEN, 32'h0000_0080);
    @(posedge clk);
    `CHK("moeoff", 1'b0, mainOutputEnable)
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("irqrst", 1'b0, irq)
    `CHK("dmarst", 13'h0000, dmaRequest)
    chkReg("status", OFS_STATUS, 32'h0000_0000);
    chkReg("ctrl", OFS_CTRL, 32'h0000_0000);
    $display("mid reset test done");
    end_sim();
  end
endmodule : tb
